// ### usart_consts.svh
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// register byte offsets on the apb window
`define OFS_TX_CTL 8'h98
`define OFS_RX_CTL 8'h9C
`define OFS_DIVISOR 8'hA0
`define OFS_TX_DATA 8'hA4
`define OFS_RX_DATA 8'hA8
`define OFS_STATUS 8'hAC

// reset values of the software-written fields
`define TX_CTL_RESET 6'h00
`define RX_CTL_RESET 4'h0
`define DIVISOR_RESET 8'h00

// generator ticks per bit, minus one
`define RATIO_SYNC_M1 6'h03
`define RATIO_ASYNC_HI_M1 6'h0F
`define RATIO_ASYNC_LO_M1 6'h3F

// frame lengths in bits, start and stop included
`define FRAME_BITS_8 4'hA
`define FRAME_BITS_9 4'hB

// receive buffer depth
`define RX_FIFO_DEPTH 16

`endif

// ### usart_pkg.sv
package usart_pkg;

    // transmit control fields, software written
    typedef struct packed {
        logic clk_src;
        logic nine_bit;
        logic tx_en;
        logic sync_mode;
        logic high_speed_select;
        logic tx_bit9;
    } tx_ctl_t;

    // receive control fields, software written
    typedef struct packed {
        logic serial_port_enable;
        logic nine_bit;
        logic single_rx;
        logic cont_rx;
    } rx_ctl_t;

    // one received character as it sits in the buffer
    typedef struct packed {
        logic frame_err;
        logic bit9;
        logic [7:0] data;
    } rx_word_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } rx_state_t;

endpackage

// ### usart_baud_and_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "usart_consts.svh"

module usart_rx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = `RX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // honest full and empty from the occupancy count
    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage, written only on an accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

module usart_baud_and_mode_control #(
    parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] port_c_direction,
    input wire logic transmit_clock_pin_in,
    output logic transmit_clock_pin_out,
    output logic transmit_clock_pin_oe_b,
    input wire logic receive_data_pin_in,
    output logic receive_data_pin_out,
    output logic receive_data_pin_oe_b
);
    usart_pkg::tx_ctl_t tx_ctl_ff;
    usart_pkg::rx_ctl_t rx_ctl_ff;
    usart_pkg::rx_word_t rx_word;
    usart_pkg::rx_word_t rx_head;
    usart_pkg::rx_state_t rx_state_ff;
    logic [7:0] baud_divisor_register_ff;
    logic [7:0] brg_cnt_ff;
    logic [5:0] tx_phase_ff;
    logic [5:0] rx_phase_ff;
    logic [5:0] ratio_m1;
    logic [5:0] half;
    logic [31:0] prdata_ff;
    logic [7:0] tx_hold_ff;
    logic tx_full_ff;
    logic [10:0] tx_shift_ff;
    logic [3:0] tx_left_ff;
    logic [8:0] rx_shift_ff;
    logic [3:0] rx_count_ff;
    logic [2:0] vote_ff;
    logic overrun_ff;
    logic rx_meta_ff;
    logic rx_sync_ff;
    logic ck_meta_ff;
    logic ck_sync_ff;
    logic setup;
    logic access;
    logic wr_en;
    logic mapped;
    logic div_wr;
    logic brg_tick;
    logic tx_bit_end;
    logic rx_bit_end;
    logic pins_owned;
    logic tx_run;
    logic rx_run;
    logic sync_master;
    logic majority;
    logic rx_push;
    logic rx_ready;
    logic rx_valid;
    logic rx_pop;

    // apb decode; one wait-free access phase after every setup
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_en = access && pwrite && pstrb[0];
    assign mapped = (paddr == `OFS_TX_CTL) || (paddr == `OFS_RX_CTL)
        || (paddr == `OFS_DIVISOR) || (paddr == `OFS_TX_DATA)
        || (paddr == `OFS_RX_DATA) || (paddr == `OFS_STATUS);
    assign pready = access;
    assign pslverr = access && !mapped;
    assign prdata = prdata_ff;
    assign div_wr = wr_en && (paddr == `OFS_DIVISOR);

    // pins belong to the transceiver only with both direction bits set
    assign pins_owned = rx_ctl_ff.serial_port_enable && (&port_c_direction);
    assign sync_master = pins_owned && tx_ctl_ff.sync_mode && tx_ctl_ff.clk_src;
    assign tx_run = pins_owned && tx_ctl_ff.tx_en && !tx_ctl_ff.sync_mode;
    assign rx_run = pins_owned && rx_ctl_ff.cont_rx && !tx_ctl_ff.sync_mode;

    // ticks per bit: speed select only counts in async mode
    assign ratio_m1 = tx_ctl_ff.sync_mode ? `RATIO_SYNC_M1
        : (tx_ctl_ff.high_speed_select ? `RATIO_ASYNC_HI_M1
        : `RATIO_ASYNC_LO_M1);
    assign half = {1'b0, ratio_m1[5:1]} + 6'h01;

    // register writes; status bits are not writable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_ctl_ff <= `TX_CTL_RESET;
            rx_ctl_ff <= `RX_CTL_RESET;
            baud_divisor_register_ff <= `DIVISOR_RESET;
        end else if (wr_en) begin
            case (paddr)
                `OFS_TX_CTL: tx_ctl_ff <= {pwdata[7:4], pwdata[2], pwdata[0]};
                `OFS_RX_CTL: rx_ctl_ff <= pwdata[7:4];
                `OFS_DIVISOR: baud_divisor_register_ff <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // read data captured in setup so the answer comes from a flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                `OFS_TX_CTL: prdata_ff <= {24'h000000, tx_ctl_ff.clk_src, tx_ctl_ff.nine_bit,
                    tx_ctl_ff.tx_en, tx_ctl_ff.sync_mode, 1'b0,
                    tx_ctl_ff.high_speed_select, (tx_left_ff == 4'h0), tx_ctl_ff.tx_bit9};
                `OFS_RX_CTL: prdata_ff <= {24'h000000, rx_ctl_ff, 1'b0,
                    rx_valid && rx_head.frame_err, overrun_ff, rx_valid && rx_head.bit9};
                `OFS_DIVISOR: prdata_ff <= {24'h000000, baud_divisor_register_ff};
                `OFS_RX_DATA: prdata_ff <= {24'h000000, rx_valid ? rx_head.data : 8'h00};
                `OFS_STATUS: prdata_ff <= {28'h0000000, rx_state_ff != usart_pkg::RX_IDLE,
                    ck_sync_ff, tx_full_ff, rx_valid};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // one free-running 8-bit timer shared by every mode
    assign brg_tick = (brg_cnt_ff == baud_divisor_register_ff);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            brg_cnt_ff <= 8'h00;
        end else if (div_wr || brg_tick) begin
            brg_cnt_ff <= 8'h00;
        end else begin
            brg_cnt_ff <= brg_cnt_ff + 8'h01;
        end
    end

    // transmit bit phase; >= guards a ratio shrunk mid-count
    assign tx_bit_end = brg_tick && (tx_phase_ff >= ratio_m1);
    always_ff @(posedge clk) begin
        if (!rst_b || div_wr) begin
            tx_phase_ff <= 6'h00;
        end else if (brg_tick) begin
            tx_phase_ff <= tx_bit_end ? 6'h00 : tx_phase_ff + 6'h01;
        end
    end

    // synchronisers for both pins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
            ck_meta_ff <= 1'b1;
            ck_sync_ff <= 1'b1;
        end else begin
            rx_meta_ff <= receive_data_pin_in;
            rx_sync_ff <= rx_meta_ff;
            ck_meta_ff <= transmit_clock_pin_in;
            ck_sync_ff <= ck_meta_ff;
        end
    end

    // transmit holding register; a write while full is dropped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_hold_ff <= 8'h00;
            tx_full_ff <= 1'b0;
        end else if (wr_en && (paddr == `OFS_TX_DATA) && !tx_full_ff) begin
            tx_hold_ff <= pwdata[7:0];
            tx_full_ff <= 1'b1;
        end else if (tx_run && tx_bit_end && (tx_left_ff == 4'h0)) begin
            tx_full_ff <= 1'b0;
        end
    end

    // transmit shifter; clearing enable aborts the frame
    always_ff @(posedge clk) begin
        if (!rst_b || !tx_run) begin
            tx_shift_ff <= 11'h7FF;
            tx_left_ff <= 4'h0;
        end else if (tx_bit_end) begin
            if (tx_left_ff != 4'h0) begin
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_left_ff <= tx_left_ff - 4'h1;
            end else if (tx_full_ff) begin
                tx_shift_ff <= {1'b1, tx_ctl_ff.nine_bit ? tx_ctl_ff.tx_bit9 : 1'b1,
                    tx_hold_ff, 1'b0};
                tx_left_ff <= tx_ctl_ff.nine_bit ? `FRAME_BITS_9 : `FRAME_BITS_8;
            end
        end
    end

    // clock pin: tx data in async, bit clock as sync master, else released
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            transmit_clock_pin_out <= 1'b1;
            transmit_clock_pin_oe_b <= 1'b1;
        end else if (sync_master) begin
            transmit_clock_pin_out <= tx_phase_ff[1];
            transmit_clock_pin_oe_b <= 1'b0;
        end else begin
            transmit_clock_pin_out <= (tx_left_ff == 4'h0) ? 1'b1 : tx_shift_ff[0];
            transmit_clock_pin_oe_b <= !tx_run;
        end
    end

    // the data pin is only ever listened to here
    assign receive_data_pin_out = 1'b1;
    assign receive_data_pin_oe_b = 1'b1;

    // three votes around the centre; majority of the three
    assign majority = (vote_ff[0] & vote_ff[1]) | (vote_ff[0] & vote_ff[2])
        | (vote_ff[1] & vote_ff[2]);
    assign rx_bit_end = brg_tick && (rx_phase_ff >= ratio_m1);

    always_ff @(posedge clk) begin
        if (!rst_b || rx_state_ff == usart_pkg::RX_IDLE) begin
            rx_phase_ff <= 6'h00;
            vote_ff <= 3'h7;
        end else if (brg_tick) begin
            rx_phase_ff <= rx_bit_end ? 6'h00 : rx_phase_ff + 6'h01;
            if (rx_phase_ff == half - 6'h01) begin
                vote_ff[0] <= rx_sync_ff;
            end
            if (rx_phase_ff == half) begin
                vote_ff[1] <= rx_sync_ff;
            end
            if (rx_phase_ff == half + 6'h01) begin
                vote_ff[2] <= rx_sync_ff;
            end
        end
    end

    // receive sequencer; a start that votes high is treated as noise
    always_ff @(posedge clk) begin
        if (!rst_b || !rx_run) begin
            rx_state_ff <= usart_pkg::RX_IDLE;
            rx_shift_ff <= 9'h000;
            rx_count_ff <= 4'h0;
        end else begin
            case (rx_state_ff)
                usart_pkg::RX_IDLE: begin
                    if (!rx_sync_ff) begin
                        rx_state_ff <= usart_pkg::RX_START;
                    end
                end
                usart_pkg::RX_START: begin
                    if (rx_bit_end) begin
                        rx_state_ff <= majority ? usart_pkg::RX_IDLE : usart_pkg::RX_DATA;
                        rx_count_ff <= rx_ctl_ff.nine_bit ? 4'h9 : 4'h8;
                    end
                end
                usart_pkg::RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_shift_ff <= rx_ctl_ff.nine_bit ? {majority, rx_shift_ff[8:1]}
                            : {1'b0, majority, rx_shift_ff[7:1]};
                        rx_count_ff <= rx_count_ff - 4'h1;
                        if (rx_count_ff == 4'h1) begin
                            rx_state_ff <= usart_pkg::RX_STOP;
                        end
                    end
                end
                usart_pkg::RX_STOP: begin
                    if (rx_bit_end) begin
                        rx_state_ff <= usart_pkg::RX_IDLE;
                    end
                end
                default: rx_state_ff <= usart_pkg::RX_IDLE;
            endcase
        end
    end

    // completed character goes to the buffer; stop bit low marks framing error
    assign rx_push = (rx_state_ff == usart_pkg::RX_STOP) && rx_bit_end;
    assign rx_word.frame_err = !majority;
    assign rx_word.bit9 = rx_shift_ff[8];
    assign rx_word.data = rx_shift_ff[7:0];
    assign rx_pop = access && !pwrite && (paddr == `OFS_RX_DATA);

    // overrun: a full buffer drops the character; cleared by dropping receive enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            overrun_ff <= 1'b0;
        end else begin
            overrun_ff <= (overrun_ff && rx_ctl_ff.cont_rx) || (rx_push && !rx_ready);
        end
    end

    usart_rx_fifo #(
        .WIDTH($bits(usart_pkg::rx_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(rx_push),
        .in_ready(rx_ready),
        .in_data(rx_word),
        .out_valid(rx_valid),
        .out_ready(rx_pop),
        .out_data(rx_head)
    );
endmodule
`default_nettype wire

// ### usart_baud_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "usart_consts.svh"
module usart_baud_sva #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] port_c_direction,
    input wire logic transmit_clock_pin_in,
    input wire logic transmit_clock_pin_out,
    input wire logic transmit_clock_pin_oe_b,
    input wire logic receive_data_pin_in,
    input wire logic receive_data_pin_out,
    input wire logic receive_data_pin_oe_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] txc_ff;
    logic [7:0] div_ff;
    logic serial_port_enable_ff;
    logic last_ff;
    logic steady_ff;
    logic [31:0] cnt_ff;
    wire logic wr = psel && penable && pwrite && pstrb[0];
    wire logic cfg = wr && (paddr inside {`OFS_TX_CTL, `OFS_RX_CTL, `OFS_DIVISOR});
    wire logic unm = !(paddr inside {`OFS_TX_CTL, `OFS_RX_CTL, `OFS_DIVISOR,
        `OFS_TX_DATA, `OFS_RX_DATA, `OFS_STATUS});
    wire logic own = serial_port_enable_ff && port_c_direction == 2'h3;
    wire logic sm = own && txc_ff[7] && txc_ff[5] && txc_ff[4];
    wire logic slave = own && !txc_ff[7] && txc_ff[4];
    wire logic tx_on = own && txc_ff[5] && !txc_ff[4];
    wire logic tog = transmit_clock_pin_out != last_ff;
    wire logic [31:0] ticks = 32'(div_ff) + 32'h1;
    wire logic [31:0] bitn = (txc_ff[2] ? 32'h10 : 32'h40) * ticks;
    // shadow of the software fields, taken when a write commits
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txc_ff <= 8'h00;
            div_ff <= 8'h00;
            serial_port_enable_ff <= 1'b0;
        end else if (wr) begin
            if (paddr == `OFS_TX_CTL) txc_ff <= pwdata[7:0];
            if (paddr == `OFS_DIVISOR) div_ff <= pwdata[7:0];
            if (paddr == `OFS_RX_CTL) serial_port_enable_ff <= pwdata[7];
        end
    end
    // cycles between pin moves; a config write voids the first gap after it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            last_ff <= 1'b1;
            cnt_ff <= 32'h0;
            steady_ff <= 1'b0;
        end else begin
            last_ff <= transmit_clock_pin_out;
            cnt_ff <= tog ? 32'h1 : cnt_ff + 32'h1;
            steady_ff <= cfg ? 1'b0 : (steady_ff || tog);
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    apb_answer_a: assert property (setup_s ##1 access_s |-> pready)
        else $error("access phase without ready");
    apb_error_a: assert property (access_s |-> pslverr == unm)
        else $error("error response does not match the map");
    pins_release_a: assert property ((port_c_direction != 2'h3) [*3] |-> transmit_clock_pin_oe_b)
        else $error("pin driven without ownership");
    rx_input_a: assert property (receive_data_pin_oe_b)
        else $error("receive pin driven");
    sync_half_a: assert property (tog && steady_ff && sm |-> cnt_ff == 32'h2 * ticks)
        else $error("sync clock half period wrong");
    async_bit_a: assert property (tog && steady_ff && tx_on |-> cnt_ff % bitn == 0)
        else $error("tx edge off the bit grid");
    slave_release_a: assert property (slave [*3] |-> transmit_clock_pin_oe_b)
        else $error("slave drives the clock pin");
    master_drive_a: assert property (sm [*3] |-> !transmit_clock_pin_oe_b)
        else $error("master leaves the clock pin");
endmodule
`default_nettype wire

// ### serial_peer.sv
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;
    // one frame; g flips one clock at the centre of data bit 1
    task automatic send(input logic [7:0] b, input int bt, input logic s, input logic g);
        logic [9:0] f;
        f = {s, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            for (int c = 0; c < bt; c++) begin
                @(posedge clk);
                line_out <= f[i] ^ (g && i == 2 && c == bt / 2);
            end
        end
        @(posedge clk);
        line_out <= 1'b1;
    endtask
    // mid-bit sampling; bit 8 of the result is the stop level
    task automatic recv(input int bt, output logic [8:0] b);
        @(negedge line_in);
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bt) @(posedge clk);
            b[i] = line_in;
        end
    endtask
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "usart_consts.svh"
module testbench;
    localparam int DEPTH = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] port_c_direction = 2'h3;
    logic transmit_clock_pin_in;
    logic transmit_clock_pin_out;
    logic transmit_clock_pin_oe_b;
    logic receive_data_pin_in;
    logic receive_data_pin_out;
    logic receive_data_pin_oe_b;
    logic peer_tx;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    // a released clock line idles high through a pull-up; the released data line carries the peer output
    assign transmit_clock_pin_in = transmit_clock_pin_oe_b ? 1'b1 : transmit_clock_pin_out;
    assign receive_data_pin_in = receive_data_pin_oe_b ? peer_tx : receive_data_pin_out;
    usart_baud_and_mode_control #(.FIFO_DEPTH(DEPTH)) dut (.clk, .rst_b, .paddr, .psel,
        .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_c_direction,
        .transmit_clock_pin_in, .transmit_clock_pin_out, .transmit_clock_pin_oe_b,
        .receive_data_pin_in, .receive_data_pin_out, .receive_data_pin_oe_b);
    serial_peer peer (.clk, .line_in(transmit_clock_pin_in), .line_out(peer_tx));
    initial begin
        forever #2 clk = ~clk;
    end
    // a hang ends the run as a failure
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors = errors + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // no wait count assumed; only the bench timeout ends a stalled access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(what, exp, r & m);
    endtask
    // clock counts from the call to the next low-to-high move of the line
    task automatic rise(output int n);
        logic p;
        n = 0;
        p = transmit_clock_pin_in;
        while (n < 2000) begin
            @(posedge clk);
            n++;
            if (p === 1'b0 && transmit_clock_pin_in === 1'b1) break;
            p = transmit_clock_pin_in;
        end
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rdchk("tx ctl", `OFS_TX_CTL, 32'hFF, 32'h02);
        rdchk("rx ctl", `OFS_RX_CTL, 32'hFE, 32'h00);
        rdchk("divisor", `OFS_DIVISOR, 32'hFF, 32'h00);
        wr(`OFS_TX_CTL, 8'hFF);
        rdchk("tx ctl rw", `OFS_TX_CTL, 32'hFFFFFFFF, 32'hF7);
        wr(`OFS_DIVISOR, 8'hA5);
        rdchk("divisor rw", `OFS_DIVISOR, 32'hFFFFFFFF, 32'hA5);
        // a write with lane 0 off must leave the register alone
        pstrb <= 4'hE;
        wr(`OFS_DIVISOR, 8'h5A);
        pstrb <= 4'hF;
        rdchk("strobe off", `OFS_DIVISOR, 32'hFF, 32'hA5);
        apb(1'b0, 8'h90, 8'h00, r, e);
        chk("hole err", 32'h1, {31'h0, e});
        chk("hole data", 32'h0, r);
    endtask
    task automatic t_owner();
        port_c_direction <= 2'h1;
        wr(`OFS_RX_CTL, 8'h90);
        wr(`OFS_TX_CTL, 8'h24);
        rdchk("pin level", `OFS_STATUS, 32'h4, 32'h4);
        chk("pin free", 32'h1, {31'h0, transmit_clock_pin_oe_b});
        port_c_direction <= 2'h3;
        rdchk("idle mark", `OFS_STATUS, 32'h4, 32'h4);
        chk("pin owned", 32'h0, {31'h0, transmit_clock_pin_oe_b});
    endtask
    task automatic t_tx(input logic hs, input logic [7:0] x, input logic [7:0] d);
        logic [8:0] got;
        wr(`OFS_TX_CTL, {5'h04, hs, 2'h0});
        wr(`OFS_DIVISOR, x);
        fork
            peer.recv((hs ? 16 : 64) * (int'(x) + 1), got);
            wr(`OFS_TX_DATA, d);
        join
        chk("tx frame", {23'h0, 1'b1, d}, {23'h0, got});
    endtask
    task automatic t_rx(input logic [7:0] d, input logic g, input logic s);
        wr(`OFS_TX_CTL, 8'h24);
        wr(`OFS_DIVISOR, 8'h00);
        peer.send(d, 16, s, g);
        // the stop bit ends a few clocks after the peer idles, behind the synchroniser
        repeat (8) @(posedge clk);
        rdchk("rx avail", `OFS_STATUS, 32'h1, 32'h1);
        rdchk("rx ferr", `OFS_RX_CTL, 32'h4, {29'h0, !s, 2'h0});
        rdchk("rx byte", `OFS_RX_DATA, 32'hFF, {24'h0, d});
    endtask
    // fill past depth while nobody reads, then drain in order
    task automatic t_overrun();
        for (int i = 0; i <= DEPTH; i++) peer.send(8'h40 + 8'(i), 16, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        rdchk("overrun", `OFS_RX_CTL, 32'h2, 32'h2);
        for (int i = 0; i < DEPTH; i++) rdchk("fifo", `OFS_RX_DATA, 32'hFF, 32'h40 + 32'(i));
        rdchk("empty", `OFS_STATUS, 32'h1, 32'h0);
        wr(`OFS_RX_CTL, 8'h80);
        rdchk("ovr clear", `OFS_RX_CTL, 32'h2, 32'h0);
        wr(`OFS_RX_CTL, 8'h90);
    endtask
    task automatic t_sync();
        int n;
        for (int h = 0; h < 2; h++) begin
            wr(`OFS_TX_CTL, 8'hB0 | 8'(h * 4));
            wr(`OFS_DIVISOR, 8'h02);
            rise(n);
            rise(n);
            chk("sync period", 32'd12, 32'(n));
        end
        wr(`OFS_DIVISOR, 8'hFF);
        rise(n);
        wr(`OFS_DIVISOR, 8'h01);
        rise(n);
        chk("new rate", 32'h1, {31'h0, n <= 12});
        wr(`OFS_TX_CTL, 8'h30);
        rdchk("slave pin", `OFS_STATUS, 32'h4, 32'h4);
        chk("slave free", 32'h1, {31'h0, transmit_clock_pin_oe_b});
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_owner();
        t_tx(1'b0, 8'h00, 8'h5A);
        t_tx(1'b1, 8'h01, 8'hA5);
        t_rx(8'h3E, 1'b1, 1'b1);
        t_rx(8'hC3, 1'b0, 1'b0);
        t_overrun();
        t_sync();
        stop_test();
    end
endmodule
bind usart_baud_and_mode_control usart_baud_sva #(.FIFO_DEPTH(FIFO_DEPTH)) sva (.clk, .rst_b,
    .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .port_c_direction, .transmit_clock_pin_in, .transmit_clock_pin_out,
    .transmit_clock_pin_oe_b, .receive_data_pin_in, .receive_data_pin_out,
    .receive_data_pin_oe_b);
`default_nettype wire
